// [hw/rtcat_top.sv]
`timescale 1ns/1ns
module rtcat_top #(
  parameter int XTAL_DIV = rtcat_pkg::XTAL_DIV
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        xtal_in,
  input  wire logic        bus_sel,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [31:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  output logic      [7:0]  bus_rdata,
  input  wire logic        timekeeper_write_enable,
  input  wire logic        alarm_global_enable,
  input  wire logic [5:0]  alarm_field_enable,
  input  wire logic        power_down,
  input  wire logic [7:0]  month_digits,
  input  wire logic [7:0]  year_digits,
  output logic             alarm_irq,
  output logic             power_wakeup,
  output logic             date_carry
);

  // ==========================================================================
  // Helpers.
  // Next BCD value with wrap to first; bit 8 is the carry out.
  function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] last, input logic [7:0] first);
    logic [8:0] r;
    r = 9'h000;
    if (v >= last) begin
      r = {1'b1, first};
    end else if (v[3:0] >= 4'h9) begin
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {1'b0, v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    return a == off;
  endfunction

  // ==========================================================================
  // Storage.
  logic [7:0] alarm_second_r;
  logic [7:0] alarm_minute_r;
  logic [7:0] alarm_hour_r;
  logic [7:0] alarm_date_r;
  logic [7:0] alarm_month_r;
  logic [7:0] alarm_year_r;
  logic [7:0] round_reset_ctrl_r;
  logic [7:0] time_second_r;
  logic [7:0] time_minute_r;
  logic [7:0] time_hour_r;
  logic [7:0] time_date_r;
  logic       round_pulse_r;
  logic       sec_tick;
  logic       tick_d1_r;
  logic       tick_d2_r;
  logic       match;
  logic       wr_en;
  logic       round_carry;
  logic       sec_carry;
  logic       min_step;
  logic [8:0] sec_nxt;
  logic [8:0] min_nxt;
  logic [8:0] hour_nxt;
  logic [8:0] date_nxt;
  logic [7:0] rdata_nxt;

  assign wr_en = bus_sel && bus_wr;

  // ==========================================================================
  // Second tick and alarm compare.
  rtcat_tick_div #(
    .DIV (XTAL_DIV)
  ) u_div (
    .clk      (clk),
    .srst     (srst),
    .xtal_in  (xtal_in),
    .sec_tick (sec_tick)
  );

  rtcat_alarm_cmp u_cmp (
    .clk          (clk),
    .srst         (srst),
    .field_enable (alarm_field_enable),
    .alarm_second (alarm_second_r),
    .alarm_minute (alarm_minute_r),
    .alarm_hour   (alarm_hour_r),
    .alarm_date   (alarm_date_r),
    .alarm_month  (alarm_month_r),
    .alarm_year   (alarm_year_r),
    .time_second  (time_second_r),
    .time_minute  (time_minute_r),
    .time_hour    (time_hour_r),
    .time_date    (time_date_r),
    .month_digits (month_digits),
    .year_digits  (year_digits),
    .match        (match)
  );

  // ==========================================================================
  // Alarm and round reset registers; written at any time.
  always_ff @(posedge clk) begin
    if (srst) begin
      alarm_second_r     <= rtcat_pkg::RST_ALARM_SECOND;
      alarm_minute_r     <= rtcat_pkg::RST_ALARM_MINUTE;
      alarm_hour_r       <= rtcat_pkg::RST_ALARM_HOUR;
      alarm_date_r       <= rtcat_pkg::RST_ALARM_DATE;
      alarm_month_r      <= rtcat_pkg::RST_ALARM_MONTH;
      alarm_year_r       <= rtcat_pkg::RST_ALARM_YEAR;
      round_reset_ctrl_r <= rtcat_pkg::RST_ROUND_RESET_CTRL;
    end else if (wr_en) begin
      if (hit(bus_addr, rtcat_pkg::OFF_ALARM_SECOND)) begin
        alarm_second_r <= bus_wdata & rtcat_pkg::MASK_SECOND;
      end
      if (hit(bus_addr, rtcat_pkg::OFF_ALARM_MINUTE)) begin
        alarm_minute_r <= bus_wdata & rtcat_pkg::MASK_MINUTE;
      end
      if (hit(bus_addr, rtcat_pkg::OFF_ALARM_HOUR)) begin
        alarm_hour_r <= bus_wdata & rtcat_pkg::MASK_HOUR;
      end
      if (hit(bus_addr, rtcat_pkg::OFF_ALARM_DATE)) begin
        alarm_date_r <= bus_wdata & rtcat_pkg::MASK_DATE;
      end
      if (hit(bus_addr, rtcat_pkg::OFF_ALARM_MONTH)) begin
        alarm_month_r <= bus_wdata & rtcat_pkg::MASK_MONTH;
      end
      if (hit(bus_addr, rtcat_pkg::OFF_ALARM_YEAR)) begin
        alarm_year_r <= bus_wdata & rtcat_pkg::MASK_YEAR;
      end
      if (hit(bus_addr, rtcat_pkg::OFF_ROUND_RESET_CTRL)) begin
        round_reset_ctrl_r <= bus_wdata & rtcat_pkg::MASK_ROUND;
      end
    end
  end

  // A write that sets the clear enable fires one round reset; the bit stays readable.
  always_ff @(posedge clk) begin
    if (srst) begin
      round_pulse_r <= 1'b0;
    end else begin
      round_pulse_r <= wr_en && hit(bus_addr, rtcat_pkg::OFF_ROUND_RESET_CTRL)
                       && bus_wdata[rtcat_pkg::ROUND_CLEAR_ENABLE_BIT];
    end
  end

  // ==========================================================================
  // Carry decisions.
  always_comb begin
    case (round_reset_ctrl_r[rtcat_pkg::CARRY_SEL_MSB:0])
      rtcat_pkg::CARRY_SEL_30: round_carry = time_second_r > rtcat_pkg::BOUNDARY_30;
      rtcat_pkg::CARRY_SEL_40: round_carry = time_second_r > rtcat_pkg::BOUNDARY_40;
      rtcat_pkg::CARRY_SEL_50: round_carry = time_second_r > rtcat_pkg::BOUNDARY_50;
      default:                 round_carry = 1'b0;
    endcase
    sec_nxt   = bcd_step(time_second_r, rtcat_pkg::MAX_SECOND, rtcat_pkg::FIRST_ZERO);
    min_nxt   = bcd_step(time_minute_r, rtcat_pkg::MAX_MINUTE, rtcat_pkg::FIRST_ZERO);
    hour_nxt  = bcd_step(time_hour_r, rtcat_pkg::MAX_HOUR, rtcat_pkg::FIRST_ZERO);
    date_nxt  = bcd_step(time_date_r, rtcat_pkg::MAX_DATE, rtcat_pkg::FIRST_DATE);
    sec_carry = sec_tick && sec_nxt[8];
    // A round reset taking place in a tick cycle wins; its carry replaces the tick's.
    min_step  = round_pulse_r ? round_carry : sec_carry;
  end

  // ==========================================================================
  // Running time. No reset: the counters keep time across a system reset.
  always_ff @(posedge clk) begin
    if (wr_en && timekeeper_write_enable && hit(bus_addr, rtcat_pkg::OFF_TIME_SECOND)) begin
      time_second_r <= bus_wdata & rtcat_pkg::MASK_SECOND;
    end else if (round_pulse_r) begin
      time_second_r <= rtcat_pkg::FIRST_ZERO;
    end else if (sec_tick) begin
      time_second_r <= sec_nxt[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (wr_en && timekeeper_write_enable && hit(bus_addr, rtcat_pkg::OFF_TIME_MINUTE)) begin
      time_minute_r <= bus_wdata & rtcat_pkg::MASK_MINUTE;
    end else if (min_step) begin
      time_minute_r <= min_nxt[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (wr_en && timekeeper_write_enable && hit(bus_addr, rtcat_pkg::OFF_TIME_HOUR)) begin
      time_hour_r <= bus_wdata & rtcat_pkg::MASK_HOUR;
    end else if (min_step && min_nxt[8]) begin
      time_hour_r <= hour_nxt[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (wr_en && timekeeper_write_enable && hit(bus_addr, rtcat_pkg::OFF_TIME_DATE)) begin
      time_date_r <= bus_wdata & rtcat_pkg::MASK_DATE;
    end else if (min_step && min_nxt[8] && hour_nxt[8]) begin
      time_date_r <= date_nxt[7:0];
    end
  end

  // Month ends are not known here; the month counter outside gets this pulse.
  always_ff @(posedge clk) begin
    if (srst) begin
      date_carry <= 1'b0;
    end else begin
      date_carry <= min_step && min_nxt[8] && hour_nxt[8] && date_nxt[8];
    end
  end

  // ==========================================================================
  // Alarm outputs, three cycles behind the tick (gated by the tick delayed two cycles) so the compare sees the new time.
  always_ff @(posedge clk) begin
    if (srst) begin
      tick_d1_r    <= 1'b0;
      tick_d2_r    <= 1'b0;
      alarm_irq    <= 1'b0;
      power_wakeup <= 1'b0;
    end else begin
      tick_d1_r    <= sec_tick;
      tick_d2_r    <= tick_d1_r;
      alarm_irq    <= tick_d2_r && match && alarm_global_enable;
      power_wakeup <= tick_d2_r && match && alarm_global_enable && power_down;
    end
  end

  // ==========================================================================
  // Byte read port. Reads work regardless of the write enable.
  always_comb begin
    rdata_nxt = 8'h00;
    if (hit(bus_addr, rtcat_pkg::OFF_ALARM_SECOND)) rdata_nxt = alarm_second_r;
    if (hit(bus_addr, rtcat_pkg::OFF_ALARM_MINUTE)) rdata_nxt = alarm_minute_r;
    if (hit(bus_addr, rtcat_pkg::OFF_ALARM_HOUR)) rdata_nxt = alarm_hour_r;
    if (hit(bus_addr, rtcat_pkg::OFF_ALARM_DATE)) rdata_nxt = alarm_date_r;
    if (hit(bus_addr, rtcat_pkg::OFF_ALARM_MONTH)) rdata_nxt = alarm_month_r;
    if (hit(bus_addr, rtcat_pkg::OFF_ALARM_YEAR)) rdata_nxt = alarm_year_r;
    if (hit(bus_addr, rtcat_pkg::OFF_ROUND_RESET_CTRL)) rdata_nxt = round_reset_ctrl_r;
    if (hit(bus_addr, rtcat_pkg::OFF_TIME_SECOND)) rdata_nxt = time_second_r;
    if (hit(bus_addr, rtcat_pkg::OFF_TIME_MINUTE)) rdata_nxt = time_minute_r;
    if (hit(bus_addr, rtcat_pkg::OFF_TIME_HOUR)) rdata_nxt = time_hour_r;
    if (hit(bus_addr, rtcat_pkg::OFF_TIME_DATE)) rdata_nxt = time_date_r;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bus_rdata <= 8'h00;
    end else if (bus_sel && bus_rd) begin
      bus_rdata <= rdata_nxt;
    end
  end

  // ==========================================================================
  // Checks.
  AST_ALARM_SECOND_RST: assert property (@(posedge clk) $fell(srst) |-> alarm_second_r == 8'h00)
    else $error("alarm second not zero after reset");
  AST_ALARM_DATE_RST: assert property (@(posedge clk) $fell(srst) |->
    (alarm_date_r == 8'h01) && (alarm_month_r == 8'h01) && (alarm_hour_r == 8'h00))
    else $error("alarm date, month or hour wrong after reset");
  AST_ALARM_MINUTE_MASK: assert property (@(posedge clk) disable iff (srst)
    wr_en && hit(bus_addr, rtcat_pkg::OFF_ALARM_MINUTE) |=> alarm_minute_r == ($past(bus_wdata) & 8'h7F))
    else $error("alarm minute write not masked to seven bits");
  AST_ALARM_HOUR_MASK: assert property (@(posedge clk) disable iff (srst) alarm_hour_r[7:6] == 2'h0)
    else $error("alarm hour reserved bits set");
  AST_ALARM_MONTH_MASK: assert property (@(posedge clk) disable iff (srst) alarm_month_r[7:5] == 3'h0)
    else $error("alarm month reserved bits set");
  AST_ALARM_YEAR_READ: assert property (@(posedge clk) disable iff (srst)
    bus_sel && bus_rd && hit(bus_addr, rtcat_pkg::OFF_ALARM_YEAR) && !wr_en |=> bus_rdata == alarm_year_r)
    else $error("alarm year readback differs");
  AST_ROUND_CTRL_MASK: assert property (@(posedge clk) disable iff (srst) round_reset_ctrl_r[7:4] == 4'h0)
    else $error("round reset control reserved bits set");
  AST_ROUND_FROM_WRITE: assert property (@(posedge clk) disable iff (srst)
    round_pulse_r |-> $past(wr_en) && $past(bus_wdata[rtcat_pkg::ROUND_CLEAR_ENABLE_BIT]))
    else $error("round reset fired without a write of the enable bit");
  AST_ROUND_CLEARS: assert property (@(posedge clk) disable iff (srst)
    round_pulse_r && !(wr_en && hit(bus_addr, rtcat_pkg::OFF_TIME_SECOND)) |=> time_second_r == 8'h00)
    else $error("round reset did not clear seconds");
  AST_ROUND_NO_CARRY: assert property (@(posedge clk) disable iff (srst)
    round_pulse_r && (round_reset_ctrl_r[2:0] < 3'h3 || round_reset_ctrl_r[2:0] > 3'h5) && !wr_en
    |=> $stable(time_minute_r))
    else $error("round reset carried with a no-carry code");
  AST_ROUND_CARRY_40: assert property (@(posedge clk) disable iff (srst)
    round_pulse_r && round_reset_ctrl_r[2:0] == 3'h4 && time_second_r > 8'h40 && time_minute_r < 8'h59 && !wr_en
    |=> time_minute_r == $past(min_nxt[7:0]))
    else $error("round reset over forty did not step minutes");
  AST_TIME_SECOND_WRITE: assert property (@(posedge clk) disable iff (srst)
    wr_en && timekeeper_write_enable && hit(bus_addr, rtcat_pkg::OFF_TIME_SECOND)
    |=> time_second_r == ($past(bus_wdata) & 8'h7F))
    else $error("time second write not stored masked");
  AST_TIME_MINUTE_WRITE: assert property (@(posedge clk) disable iff (srst)
    wr_en && timekeeper_write_enable && hit(bus_addr, rtcat_pkg::OFF_TIME_MINUTE)
    |=> time_minute_r == ($past(bus_wdata) & 8'h7F))
    else $error("time minute write not stored masked");
  AST_TIME_DATE_RSVD: assert property (@(posedge clk) disable iff (srst)
    wr_en && timekeeper_write_enable && hit(bus_addr, rtcat_pkg::OFF_TIME_DATE)
    |=> time_date_r[7:6] == 2'h0)
    else $error("time date reserved bits set by a write");
  AST_WRITE_LOCK: assert property (@(posedge clk) disable iff (srst)
    wr_en && !timekeeper_write_enable && hit(bus_addr, rtcat_pkg::OFF_TIME_HOUR) && !min_step
    |=> $stable(time_hour_r))
    else $error("time hour written while locked");
  AST_WAKEUP_WITH_IRQ: assert property (@(posedge clk) disable iff (srst) power_wakeup |-> alarm_irq)
    else $error("wakeup without alarm interrupt");
  AST_WAKEUP_NEEDS_DOWN: assert property (@(posedge clk) disable iff (srst)
    power_wakeup |-> $past(power_down))
    else $error("wakeup outside power-down mode");
  AST_IRQ_ONE_CYCLE: assert property (@(posedge clk) disable iff (srst) alarm_irq |=> !alarm_irq)
    else $error("alarm interrupt longer than one cycle");
  AST_IRQ_NEEDS_ENABLE: assert property (@(posedge clk) disable iff (srst)
    alarm_irq |-> $past(alarm_global_enable) && $past(tick_d2_r, 1))
    else $error("alarm interrupt without global enable or tick");
  AST_SECOND_WRAP: assert property (@(posedge clk) disable iff (srst)
    sec_tick && time_second_r == 8'h59 && !round_pulse_r && !wr_en |=> time_second_r == 8'h00)
    else $error("seconds did not wrap at fifty-nine");
  AST_HOUR_WRAP: assert property (@(posedge clk) disable iff (srst)
    min_step && min_nxt[8] && time_hour_r == 8'h23 && !wr_en |=> time_hour_r == 8'h00)
    else $error("hours did not wrap at twenty-three");
  AST_DATE_CARRY_WRAP: assert property (@(posedge clk) disable iff (srst)
    date_carry && !$past(wr_en) |-> time_date_r == 8'h01)
    else $error("date carry without the date wrapping to one");

  COV_ROUND_CARRY: cover property (@(posedge clk) disable iff (srst) round_pulse_r && round_carry);
  COV_LOCKED_WRITE: cover property (@(posedge clk) disable iff (srst) wr_en && !timekeeper_write_enable);
  COV_ALARM_FIRE: cover property (@(posedge clk) disable iff (srst) alarm_irq && power_wakeup);
  COV_HOUR_WRAP: cover property (@(posedge clk) disable iff (srst) min_step && min_nxt[8] && hour_nxt[8]);

endmodule

// [include/rtcat_pkg.sv]
package rtcat_pkg;

  // ==========================================================================
  // Register byte addresses.
  localparam logic [31:0] OFF_ALARM_SECOND     = 32'h4420_0054;
  localparam logic [31:0] OFF_ALARM_MINUTE     = 32'h4420_0058;
  localparam logic [31:0] OFF_ALARM_HOUR       = 32'h4420_005C;
  localparam logic [31:0] OFF_ALARM_DATE       = 32'h4420_0060;
  localparam logic [31:0] OFF_ALARM_MONTH      = 32'h4420_0064;
  localparam logic [31:0] OFF_ALARM_YEAR       = 32'h4420_0068;
  localparam logic [31:0] OFF_ROUND_RESET_CTRL = 32'h4420_006C;
  localparam logic [31:0] OFF_TIME_SECOND      = 32'h4420_0070;
  localparam logic [31:0] OFF_TIME_MINUTE      = 32'h4420_0074;
  localparam logic [31:0] OFF_TIME_HOUR        = 32'h4420_0078;
  localparam logic [31:0] OFF_TIME_DATE        = 32'h4420_007C;

  // ==========================================================================
  // Values after reset.
  localparam logic [7:0] RST_ALARM_SECOND     = 8'h00;
  localparam logic [7:0] RST_ALARM_MINUTE     = 8'h00;
  localparam logic [7:0] RST_ALARM_HOUR       = 8'h00;
  localparam logic [7:0] RST_ALARM_DATE       = 8'h01;
  localparam logic [7:0] RST_ALARM_MONTH      = 8'h01;
  localparam logic [7:0] RST_ALARM_YEAR       = 8'h00;
  localparam logic [7:0] RST_ROUND_RESET_CTRL = 8'h00;

  // ==========================================================================
  // Implemented bits of each register; the rest are reserved and read zero.
  localparam logic [7:0] MASK_SECOND = 8'h7F;
  localparam logic [7:0] MASK_MINUTE = 8'h7F;
  localparam logic [7:0] MASK_HOUR   = 8'h3F;
  localparam logic [7:0] MASK_DATE   = 8'h3F;
  localparam logic [7:0] MASK_MONTH  = 8'h1F;
  localparam logic [7:0] MASK_YEAR   = 8'hFF;
  localparam logic [7:0] MASK_ROUND  = 8'h0F;

  // ==========================================================================
  // Round reset control fields and boundary codes.
  localparam int         ROUND_CLEAR_ENABLE_BIT = 3;
  localparam int         CARRY_SEL_MSB          = 2;
  localparam logic [2:0] CARRY_SEL_30           = 3'h3;
  localparam logic [2:0] CARRY_SEL_40           = 3'h4;
  localparam logic [2:0] CARRY_SEL_50           = 3'h5;
  localparam logic [7:0] BOUNDARY_30            = 8'h30;
  localparam logic [7:0] BOUNDARY_40            = 8'h40;
  localparam logic [7:0] BOUNDARY_50            = 8'h50;

  // ==========================================================================
  // Counting limits and the crystal divider.
  localparam logic [7:0] MAX_SECOND  = 8'h59;
  localparam logic [7:0] MAX_MINUTE  = 8'h59;
  localparam logic [7:0] MAX_HOUR    = 8'h23;
  localparam logic [7:0] MAX_DATE    = 8'h31;
  localparam logic [7:0] FIRST_ZERO  = 8'h00;
  localparam logic [7:0] FIRST_DATE  = 8'h01;
  localparam int         XTAL_DIV    = 32768;
  localparam int         FIELD_COUNT = 6;

endpackage

// [hw/rtcat_tick_div.sv]
`timescale 1ns/1ns
module rtcat_tick_div #(
  parameter int DIV = rtcat_pkg::XTAL_DIV
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic xtal_in,
  output logic      sec_tick
);

  logic        sync1_r;
  logic        sync2_r;
  logic        sync3_r;
  logic [15:0] cnt_r;

  // The crystal wave is asynchronous; the second and third stages feed the edge detect.
  always_ff @(posedge clk) begin
    sync1_r <= xtal_in;
    sync2_r <= sync1_r;
    sync3_r <= sync2_r;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r    <= 16'h0000;
      sec_tick <= 1'b0;
    end else begin
      sec_tick <= 1'b0;
      if (sync2_r && !sync3_r) begin
        if (cnt_r == 16'(DIV - 1)) begin
          cnt_r    <= 16'h0000;
          sec_tick <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 16'h0001;
        end
      end
    end
  end

endmodule

// [hw/rtcat_alarm_cmp.sv]
`timescale 1ns/1ns
module rtcat_alarm_cmp (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [5:0] field_enable,
  input  wire logic [7:0] alarm_second,
  input  wire logic [7:0] alarm_minute,
  input  wire logic [7:0] alarm_hour,
  input  wire logic [7:0] alarm_date,
  input  wire logic [7:0] alarm_month,
  input  wire logic [7:0] alarm_year,
  input  wire logic [7:0] time_second,
  input  wire logic [7:0] time_minute,
  input  wire logic [7:0] time_hour,
  input  wire logic [7:0] time_date,
  input  wire logic [7:0] month_digits,
  input  wire logic [7:0] year_digits,
  output logic            match
);

  logic [5:0] eq;

  always_comb begin
    eq[0] = (alarm_second == time_second);
    eq[1] = (alarm_minute == time_minute);
    eq[2] = (alarm_hour   == time_hour);
    eq[3] = (alarm_date   == time_date);
    eq[4] = (alarm_month  == month_digits);
    eq[5] = (alarm_year   == year_digits);
  end

  // A field whose enable is clear always counts as matching.
  always_ff @(posedge clk) begin
    if (srst) begin
      match <= 1'b0;
    end else begin
      match <= &(eq | ~field_enable);
    end
  end

endmodule

// [dv/rtcat_cpu_model.sv]
`timescale 1ns/1ns
// ==========================================================================
// Processor side of the register bus, one byte per access.
module rtcat_cpu_model (
  input  wire logic        clk,
  input  wire logic [7:0]  bus_rdata,
  output logic             bus_sel,
  output logic             bus_wr,
  output logic             bus_rd,
  output logic      [31:0] bus_addr,
  output logic      [7:0]  bus_wdata,
  output logic             timekeeper_write_enable
);
  initial begin
    bus_sel = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 32'h0000_0000;
    bus_wdata = 8'h00;
    timekeeper_write_enable = 1'b0;
  end
  // Released lines are inverted so the block cannot lean on a stale address or byte.
  task automatic put(input logic [31:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_sel <= 1'b1;
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_sel <= 1'b0;
    bus_wr <= 1'b0;
    bus_addr <= ~a;
    bus_wdata <= ~d;
  endtask
  task automatic get(input logic [31:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_sel <= 1'b1;
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_sel <= 1'b0;
    bus_rd <= 1'b0;
    bus_addr <= ~a;
    #1;
    d = bus_rdata;
  endtask
  // Software raises the enable before writing time registers and drops it before power off.
  task automatic time_access(input logic on);
    @(posedge clk);
    timekeeper_write_enable <= on;
  endtask
endmodule

// [dv/test_rtcat_top.sv]
`timescale 1ns/1ns
module test_rtcat_top;
  // ==========================================================================
  // Stimulus and observation.
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        xtal_in = 1'b0;
  logic        alarm_global_enable = 1'b0;
  logic [5:0]  alarm_field_enable = 6'h00;
  logic        power_down = 1'b0;
  logic [7:0]  month_digits = 8'h01;
  logic [7:0]  year_digits = 8'h00;
  logic        bus_sel;
  logic        bus_wr;
  logic        bus_rd;
  logic [31:0] bus_addr;
  logic [7:0]  bus_wdata;
  logic [7:0]  bus_rdata;
  logic        twe;
  logic        alarm_irq;
  logic        power_wakeup;
  logic        date_carry;
  logic [7:0]  got;
  int          miscompares = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          irq_n = 0;
  int          wake_n = 0;
  int          carry_n = 0;
  localparam logic [31:0] RA [7] = '{rtcat_pkg::OFF_ALARM_SECOND, rtcat_pkg::OFF_ALARM_MINUTE,
    rtcat_pkg::OFF_ALARM_HOUR, rtcat_pkg::OFF_ALARM_DATE, rtcat_pkg::OFF_ALARM_MONTH,
    rtcat_pkg::OFF_ALARM_YEAR, rtcat_pkg::OFF_ROUND_RESET_CTRL};
  localparam logic [7:0] RV [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00};
  localparam logic [7:0] RM [7] = '{8'h7F, 8'h7F, 8'h3F, 8'h3F, 8'h1F, 8'hFF, 8'h0F};
  localparam logic [2:0] RC [9] = '{3'h4, 3'h3, 3'h5, 3'h2, 3'h3, 3'h0, 3'h1, 3'h6, 3'h7};
  localparam logic [7:0] RS [9] = '{8'h47, 8'h25, 8'h51, 8'h55, 8'h30, 8'h59, 8'h45, 8'h58, 8'h52};
  localparam logic [7:0] RN [9] = '{8'h38, 8'h37, 8'h38, 8'h37, 8'h37, 8'h37, 8'h37, 8'h37, 8'h37};
  always #10 clk = ~clk;
  rtcat_top #(.XTAL_DIV(4)) dut (.clk(clk), .srst(srst), .xtal_in(xtal_in), .bus_sel(bus_sel),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .timekeeper_write_enable(twe), .alarm_global_enable(alarm_global_enable),
    .alarm_field_enable(alarm_field_enable), .power_down(power_down), .month_digits(month_digits),
    .year_digits(year_digits), .alarm_irq(alarm_irq), .power_wakeup(power_wakeup), .date_carry(date_carry));
  rtcat_cpu_model cpu (.clk(clk), .bus_rdata(bus_rdata), .bus_sel(bus_sel), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .timekeeper_write_enable(twe));
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (alarm_irq === 1'b1) irq_n <= irq_n + 1;
    if (power_wakeup === 1'b1) wake_n <= wake_n + 1;
    if (date_carry === 1'b1) carry_n <= carry_n + 1;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end
  // ==========================================================================
  // Shared helpers.
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [7:0] e);
    cpu.get(a, got);
    check_count++;
    if (got !== e) begin
      miscompares++;
      $display("ERROR %0t: at %h read %h expected %h", $time, a, got, e);
    end
  endtask
  task automatic n_chk(input int g, input int e);
    check_count++;
    if (g != e) begin
      miscompares++;
      $display("ERROR %0t: saw %0d pulses expected %0d", $time, g, e);
    end
  endtask
  // Four crystal rising edges make one second at the reduced divider.
  task automatic tick_once();
    #1;
    irq_n = 0;
    wake_n = 0;
    carry_n = 0;
    repeat (4) begin
      @(posedge clk) xtal_in <= 1'b1;
      repeat (3) @(posedge clk);
      xtal_in <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (10) @(posedge clk);
    #1;
  endtask
  // ==========================================================================
  // Scenarios.
  task automatic t_regs();
    for (int i = 0; i < 7; i++) begin
      rd_chk(RA[i], RV[i]);
      cpu.put(RA[i], 8'hFF);
      rd_chk(RA[i], RM[i]);
      cpu.put(RA[i], RV[i]);
    end
    rd_chk(32'h4420_0090, 8'h00);
  endtask
  task automatic t_time();
    cpu.time_access(1'b1);
    cpu.put(rtcat_pkg::OFF_TIME_SECOND, 8'h33);
    cpu.time_access(1'b0);
    cpu.put(rtcat_pkg::OFF_TIME_SECOND, 8'h12);
    rd_chk(rtcat_pkg::OFF_TIME_SECOND, 8'h33);
    cpu.time_access(1'b1);
    cpu.put(rtcat_pkg::OFF_TIME_SECOND, 8'hFF);
    rd_chk(rtcat_pkg::OFF_TIME_SECOND, 8'h7F);
    cpu.put(rtcat_pkg::OFF_TIME_MINUTE, 8'hFF);
    rd_chk(rtcat_pkg::OFF_TIME_MINUTE, 8'h7F);
    cpu.put(rtcat_pkg::OFF_TIME_HOUR, 8'hFF);
    rd_chk(rtcat_pkg::OFF_TIME_HOUR, 8'h3F);
    cpu.put(rtcat_pkg::OFF_TIME_DATE, 8'hFF);
    rd_chk(rtcat_pkg::OFF_TIME_DATE, 8'h3F);
  endtask
  task automatic t_round();
    cpu.put(rtcat_pkg::OFF_TIME_HOUR, 8'h23);
    for (int i = 0; i < 9; i++) begin
      cpu.put(rtcat_pkg::OFF_TIME_SECOND, RS[i]);
      cpu.put(rtcat_pkg::OFF_TIME_MINUTE, 8'h37);
      cpu.put(rtcat_pkg::OFF_ROUND_RESET_CTRL, {5'h01, RC[i]});
      rd_chk(rtcat_pkg::OFF_TIME_SECOND, 8'h00);
      rd_chk(rtcat_pkg::OFF_TIME_MINUTE, RN[i]);
    end
  endtask
  task automatic t_count();
    cpu.put(rtcat_pkg::OFF_TIME_SECOND, 8'h59);
    cpu.put(rtcat_pkg::OFF_TIME_MINUTE, 8'h59);
    cpu.put(rtcat_pkg::OFF_TIME_HOUR, 8'h23);
    cpu.put(rtcat_pkg::OFF_TIME_DATE, 8'h31);
    @(posedge clk) alarm_field_enable <= 6'h01;
    alarm_global_enable <= 1'b1;
    power_down <= 1'b1;
    tick_once();
    rd_chk(rtcat_pkg::OFF_TIME_SECOND, 8'h00);
    rd_chk(rtcat_pkg::OFF_TIME_MINUTE, 8'h00);
    rd_chk(rtcat_pkg::OFF_TIME_HOUR, 8'h00);
    rd_chk(rtcat_pkg::OFF_TIME_DATE, 8'h01);
    n_chk(carry_n, 1);
    n_chk(irq_n, 1);
    n_chk(wake_n, 1);
    tick_once();
    rd_chk(rtcat_pkg::OFF_TIME_SECOND, 8'h01);
    n_chk(irq_n, 0);
    cpu.put(rtcat_pkg::OFF_ALARM_SECOND, 8'h02);
    @(posedge clk) alarm_global_enable <= 1'b0;
    power_down <= 1'b0;
    tick_once();
    n_chk(irq_n, 0);
    cpu.put(rtcat_pkg::OFF_ALARM_SECOND, 8'h03);
    @(posedge clk) alarm_global_enable <= 1'b1;
    tick_once();
    n_chk(irq_n, 1);
    n_chk(wake_n, 0);
    @(posedge clk) alarm_field_enable <= 6'h30;
    month_digits <= 8'h02;
    tick_once();
    n_chk(irq_n, 0);
    @(posedge clk) month_digits <= 8'h01;
    year_digits <= 8'h01;
    tick_once();
    n_chk(irq_n, 0);
    @(posedge clk) year_digits <= 8'h00;
    tick_once();
    n_chk(irq_n, 1);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    // Time counters are written first, so the round reset fired by the register sweep acts on known values.
    t_time();
    t_regs();
    t_round();
    t_count();
    test_done();
  end
endmodule
